/* verilog/flash_flag_pkg.sv */
// Constants and types shared by the flag register and command decoder
`default_nettype none
package flash_flag_pkg;
   // Protocol selection codes
   localparam logic [1:0] PROTO_EXT = 2'h0;
   localparam logic [1:0] PROTO_DUAL = 2'h1;
   localparam logic [1:0] PROTO_QUAD = 2'h2;
   // Support masks, bit index is the protocol code
   localparam logic [2:0] SUP_ALL = 3'h7;
   localparam logic [2:0] SUP_EXT = 3'h1;
   localparam logic [2:0] SUP_ED = 3'h3;
   localparam logic [2:0] SUP_EQ = 3'h5;
   localparam logic [2:0] SUP_DQ = 3'h6;
   localparam logic [2:0] SUP_NONE = 3'h0;
   // Data byte limits
   localparam logic [8:0] BYTES_0 = 9'h000;
   localparam logic [8:0] BYTES_1 = 9'h001;
   localparam logic [8:0] BYTES_2 = 9'h002;
   localparam logic [8:0] BYTES_ID_MULTI = 9'h003;
   localparam logic [8:0] BYTES_ID = 9'h014;
   localparam logic [8:0] BYTES_OTP = 9'h040;
   localparam logic [8:0] BYTES_PAGE = 9'h100;
   localparam logic [8:0] BYTES_MAX = 9'h1FF;
   // Opcodes
   localparam logic [7:0] OP_RST_EN = 8'h66, OP_RST_MEM = 8'h99;
   localparam logic [7:0] OP_ID_A = 8'h9E, OP_ID_B = 8'h9F, OP_ID_MULTI = 8'hAF;
   localparam logic [7:0] OP_DISCOVERY = 8'h5A, OP_READ = 8'h03, OP_FAST = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B, OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B, OP_QUAD_IO = 8'hEB;
   localparam logic [7:0] OP_WREN = 8'h06, OP_WRDIS = 8'h04;
   localparam logic [7:0] OP_RD_STATUS = 8'h05, OP_WR_STATUS = 8'h01;
   localparam logic [7:0] OP_RD_LOCK = 8'hE8, OP_WR_LOCK = 8'hE5;
   localparam logic [7:0] OP_RD_FLAG = 8'h70, OP_CLR_FLAG = 8'h50;
   localparam logic [7:0] OP_RD_NVCFG = 8'hB5, OP_WR_NVCFG = 8'hB1;
   localparam logic [7:0] OP_RD_VCFG = 8'h85, OP_WR_VCFG = 8'h81;
   localparam logic [7:0] OP_RD_EVCFG = 8'h65, OP_WR_EVCFG = 8'h61;
   localparam logic [7:0] OP_PAGE_PROG = 8'h02, OP_DUAL_PROG = 8'hA2;
   localparam logic [7:0] OP_DUAL_XPROG = 8'hD2, OP_QUAD_PROG = 8'h32;
   localparam logic [7:0] OP_QUAD_XPROG = 8'h12;
   localparam logic [7:0] OP_SUB_ERASE = 8'h20, OP_SEC_ERASE = 8'hD8;
   localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
   localparam logic [7:0] OP_RESUME = 8'h7A, OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RD_OTP = 8'h4B, OP_PROG_OTP = 8'h42;
   localparam logic [7:0] OP_DPD = 8'hB9, OP_DPD_EXIT = 8'hAB;
   // Flag register layout
   localparam int FLAG_READY = 7;
   localparam int FLAG_ERASE_SUSP = 6;
   localparam int FLAG_ERASE_ERR = 5;
   localparam int FLAG_PROG_ERR = 4;
   localparam int FLAG_SUPPLY_ERR = 3;
   localparam int FLAG_PROG_SUSP = 2;
   localparam int FLAG_PROT_ERR = 1;
   localparam int FLAG_RSVD = 0;
   localparam logic [7:0] FLAG_ERR_MASK = 8'h3A;
   localparam logic [7:0] FLAG_RESET = 8'h88;
   // Pattern granularity for the zero-to-one check, low bits that must be zero
   localparam int PATTERN_LOG2 = 6;

   typedef struct packed {
      logic [2:0] sup;
      logic [8:0] maxb;
      logic inf;
   } dec_s;
endpackage
`default_nettype wire

/* verilog/opcode_dec_if.sv */
// Carrier between the flag block and its opcode decoder
`timescale 1ns/100ps
`default_nettype none
interface opcode_dec_if;
   logic [7:0] opcode;
   logic [1:0] proto;
   logic hit;
   logic [8:0] maxb;
   logic inf;
   modport ctrl (output opcode, output proto, input hit, input maxb, input inf);
   modport dec (input opcode, input proto, output hit, output maxb, output inf);
endinterface
`default_nettype wire

/* verilog/opcode_decoder.sv */
// Opcode table: protocol support and data byte limits
`timescale 1ns/100ps
`default_nettype none
module opcode_decoder (
   opcode_dec_if.dec d
);
   function automatic flash_flag_pkg::dec_s mk(input logic [2:0] s, input logic [8:0] m,
                                                input logic i);
      flash_flag_pkg::dec_s r;
      r.sup = s;
      r.maxb = m;
      r.inf = i;
      return r;
   endfunction

   flash_flag_pkg::dec_s e;

   always_comb begin
      unique case (d.opcode)
         flash_flag_pkg::OP_RST_EN, flash_flag_pkg::OP_RST_MEM,
         flash_flag_pkg::OP_WREN, flash_flag_pkg::OP_WRDIS,
         flash_flag_pkg::OP_SUB_ERASE, flash_flag_pkg::OP_SEC_ERASE,
         flash_flag_pkg::OP_BULK_ERASE, flash_flag_pkg::OP_RESUME,
         flash_flag_pkg::OP_SUSPEND, flash_flag_pkg::OP_DPD,
         flash_flag_pkg::OP_DPD_EXIT:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_0, 1'b0);
         flash_flag_pkg::OP_CLR_FLAG:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_0, 1'b0);
         flash_flag_pkg::OP_ID_A, flash_flag_pkg::OP_ID_B:
            e = mk(flash_flag_pkg::SUP_EXT, flash_flag_pkg::BYTES_ID, 1'b0);
         flash_flag_pkg::OP_ID_MULTI:
            e = mk(flash_flag_pkg::SUP_DQ, flash_flag_pkg::BYTES_ID_MULTI, 1'b0);
         flash_flag_pkg::OP_READ:
            e = mk(flash_flag_pkg::SUP_EXT, flash_flag_pkg::BYTES_MAX, 1'b1);
         flash_flag_pkg::OP_DISCOVERY, flash_flag_pkg::OP_FAST,
         flash_flag_pkg::OP_RD_STATUS, flash_flag_pkg::OP_RD_FLAG,
         flash_flag_pkg::OP_RD_VCFG, flash_flag_pkg::OP_RD_EVCFG:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_MAX, 1'b1);
         flash_flag_pkg::OP_RD_LOCK:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_MAX, 1'b1);
         flash_flag_pkg::OP_DUAL_OUT, flash_flag_pkg::OP_DUAL_IO:
            e = mk(flash_flag_pkg::SUP_ED, flash_flag_pkg::BYTES_MAX, 1'b1);
         flash_flag_pkg::OP_QUAD_OUT, flash_flag_pkg::OP_QUAD_IO:
            e = mk(flash_flag_pkg::SUP_EQ, flash_flag_pkg::BYTES_MAX, 1'b1);
         flash_flag_pkg::OP_WR_STATUS, flash_flag_pkg::OP_WR_LOCK,
         flash_flag_pkg::OP_WR_VCFG, flash_flag_pkg::OP_WR_EVCFG:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_1, 1'b0);
         flash_flag_pkg::OP_RD_NVCFG, flash_flag_pkg::OP_WR_NVCFG:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_2, 1'b0);
         flash_flag_pkg::OP_PAGE_PROG:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_PAGE, 1'b0);
         flash_flag_pkg::OP_DUAL_PROG, flash_flag_pkg::OP_DUAL_XPROG:
            e = mk(flash_flag_pkg::SUP_ED, flash_flag_pkg::BYTES_PAGE, 1'b0);
         flash_flag_pkg::OP_QUAD_PROG, flash_flag_pkg::OP_QUAD_XPROG:
            e = mk(flash_flag_pkg::SUP_EQ, flash_flag_pkg::BYTES_PAGE, 1'b0);
         flash_flag_pkg::OP_RD_OTP, flash_flag_pkg::OP_PROG_OTP:
            e = mk(flash_flag_pkg::SUP_ALL, flash_flag_pkg::BYTES_OTP, 1'b0);
         default:
            e = mk(flash_flag_pkg::SUP_NONE, flash_flag_pkg::BYTES_0, 1'b0);
      endcase
   end

   // Protocol code 3 is not a protocol, so nothing hits there
   assign d.hit = (d.proto != 2'h3) && e.sup[d.proto];
   assign d.maxb = e.maxb;
   assign d.inf = e.inf;
endmodule // opcode_decoder
`default_nettype wire

/* verilog/flash_flag_status_cmd_decode.sv */
// Flag register and per-protocol command acceptance for the serial flash
// Functional notes
// - bit 7 low busy, high ready
// - bit 6 shows erase suspended or pending
// - bit 5 sets on erase failure/protection
// - bit 4 sets on program failure, 0-to-1 attempt at high supply level with whole pattern
// - bit 3 flags bad program supply, resets 1
// - bit 2 shows program suspended or pending
// - bit 1 protection error, bit 0 reserved
// - read-flag opcode returns volatile register, all protocols
// - status bits follow their condition automatically
// - error bits stick until clear-flag opcode
// - new operation with pending error is error
// - clear-flag in all protocols, no data
// - identification reads split by protocol
// - dual output read refused in quad, streams
// - dual I/O read codes refused in quad
// - quad output read refused in dual, streams
// - quad I/O read codes refused in dual
// - status read streams, status write one byte
`timescale 1ns/100ps
`default_nettype none
module flash_flag_status_cmd_decode (
   // Clock, reset, enable
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Serial front end
   input wire logic cs_n_i,
   input wire logic opcode_valid_i,
   input wire logic [7:0] opcode_i,
   input wire logic [1:0] proto_i,
   input wire logic byte_done_i,
   // Program/erase engine
   input wire logic pe_busy_i,
   input wire logic erase_susp_i,
   input wire logic prog_susp_i,
   input wire logic op_start_i,
   input wire logic erase_fail_i,
   input wire logic erase_prot_i,
   input wire logic prog_fail_i,
   input wire logic prog_prot_i,
   input wire logic otp_locked_hit_i,
   input wire logic supply_bad_i,
   input wire logic zero_to_one_i,
   input wire logic program_supply_high_level_i,
   input wire logic [11:0] pattern_bits_i,
   // Command results
   output logic [7:0] flag_o,
   output logic cmd_accept_o,
   output logic cmd_ignored_o,
   output logic [7:0] cmd_code_o,
   output logic [8:0] max_bytes_o,
   output logic stream_o,
   output logic byte_over_o,
   output logic clear_done_o,
   output logic rd_valid_o,
   output logic [7:0] rd_data_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_IGNORE} state_e;

   function automatic logic pattern_whole(input logic [11:0] bits);
      return bits[flash_flag_pkg::PATTERN_LOG2-1:0] == '0;
   endfunction

   opcode_dec_if dif ();
   opcode_decoder u_dec (
      .d (dif)
   );
   assign dif.opcode = opcode_i;
   assign dif.proto = proto_i;

   state_e state_r, state_nxt;
   logic cs_s1_r, cs_s2_r;
   logic [7:0] flag_r, flag_nxt;
   logic [7:0] code_r, code_nxt;
   logic [8:0] max_r, max_nxt;
   logic [8:0] cnt_r, cnt_nxt;
   logic stream_r, stream_nxt;
   logic over_r, over_nxt;
   logic acc_r, acc_nxt;
   logic ign_r, ign_nxt;
   logic clr_r, clr_nxt;
   logic rdv_r, rdv_nxt;
   logic [7:0] rdd_r, rdd_nxt;
   logic clr_now;
   logic pending_err;

   // Select is a pin; the first stage is read only by the second
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
      end else if (ce_i) begin
         cs_s1_r <= cs_n_i;
         cs_s2_r <= cs_s1_r;
      end
   end

   // Framing and acceptance
   always_comb begin
      state_nxt = state_r;
      code_nxt = code_r;
      max_nxt = max_r;
      cnt_nxt = cnt_r;
      stream_nxt = stream_r;
      over_nxt = over_r;
      acc_nxt = 1'b0;
      ign_nxt = 1'b0;
      clr_now = 1'b0;
      rdv_nxt = 1'b0;
      rdd_nxt = rdd_r;
      unique case (state_r)
         ST_IDLE: begin
            if (opcode_valid_i && !cs_s2_r) begin
               if (dif.hit) begin
                  state_nxt = ST_CMD;
                  acc_nxt = 1'b1;
                  code_nxt = opcode_i;
                  max_nxt = dif.maxb;
                  stream_nxt = dif.inf;
                  cnt_nxt = '0;
                  over_nxt = 1'b0;
                  clr_now = (opcode_i == flash_flag_pkg::OP_CLR_FLAG);
               end else begin
                  state_nxt = ST_IGNORE;
                  ign_nxt = 1'b1;
               end
            end
         end
         ST_CMD: begin
            if (cs_s2_r) begin
               state_nxt = ST_IDLE;
               stream_nxt = 1'b0;
            end else if (byte_done_i) begin
               if (cnt_r != flash_flag_pkg::BYTES_MAX) begin
                  cnt_nxt = cnt_r + 9'h001;
               end
               if (!stream_r && cnt_r >= max_r) begin
                  over_nxt = 1'b1;
               end
               if (code_r == flash_flag_pkg::OP_RD_FLAG) begin
                  rdv_nxt = 1'b1;
                  rdd_nxt = flag_r;
               end
            end
         end
         ST_IGNORE: begin
            if (cs_s2_r) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
      clr_nxt = clr_now;
   end

   // Flag register
   always_comb begin
      pending_err = |(flag_r & flash_flag_pkg::FLAG_ERR_MASK);
      flag_nxt = flag_r;
      // only the clear opcode drops errors
      if (clr_now) begin
         flag_nxt = flag_r & ~flash_flag_pkg::FLAG_ERR_MASK;
      end
      flag_nxt[flash_flag_pkg::FLAG_READY] = !pe_busy_i;
      flag_nxt[flash_flag_pkg::FLAG_ERASE_SUSP] = erase_susp_i;
      flag_nxt[flash_flag_pkg::FLAG_PROG_SUSP] = prog_susp_i;
      flag_nxt[flash_flag_pkg::FLAG_RSVD] = 1'b0;
      if (erase_fail_i || erase_prot_i) begin
         flag_nxt[flash_flag_pkg::FLAG_ERASE_ERR] = 1'b1;
      end
      if (prog_fail_i || prog_prot_i || otp_locked_hit_i ||
          (zero_to_one_i && program_supply_high_level_i && pattern_whole(pattern_bits_i))) begin
         flag_nxt[flash_flag_pkg::FLAG_PROG_ERR] = 1'b1;
      end
      if (supply_bad_i) begin
         flag_nxt[flash_flag_pkg::FLAG_SUPPLY_ERR] = 1'b1;
      end
      if (erase_prot_i || prog_prot_i || otp_locked_hit_i || (op_start_i && pending_err)) begin
         flag_nxt[flash_flag_pkg::FLAG_PROT_ERR] = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         flag_r <= flash_flag_pkg::FLAG_RESET;
         code_r <= '0;
         max_r <= '0;
         cnt_r <= '0;
         stream_r <= 1'b0;
         over_r <= 1'b0;
         acc_r <= 1'b0;
         ign_r <= 1'b0;
         clr_r <= 1'b0;
         rdv_r <= 1'b0;
         rdd_r <= '0;
      end else if (ce_i) begin
         state_r <= state_nxt;
         flag_r <= flag_nxt;
         code_r <= code_nxt;
         max_r <= max_nxt;
         cnt_r <= cnt_nxt;
         stream_r <= stream_nxt;
         over_r <= over_nxt;
         acc_r <= acc_nxt;
         ign_r <= ign_nxt;
         clr_r <= clr_nxt;
         rdv_r <= rdv_nxt;
         rdd_r <= rdd_nxt;
      end
   end

   assign flag_o = flag_r;
   assign cmd_accept_o = acc_r;
   assign cmd_ignored_o = ign_r;
   assign cmd_code_o = code_r;
   assign max_bytes_o = max_r;
   assign stream_o = stream_r;
   assign byte_over_o = over_r;
   assign clear_done_o = clr_r;
   assign rd_valid_o = rdv_r;
   assign rd_data_o = rdd_r;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_READY_BUSY: assert property (ce_i && pe_busy_i |=> !flag_o[7])
      else $error("ready bit high while engine busy");
   AST_READY_IDLE: assert property (ce_i && !pe_busy_i |=> flag_o[7])
      else $error("ready bit low while engine idle");
   AST_ERASE_SUSP: assert property (ce_i |=> flag_o[6] == $past(erase_susp_i))
      else $error("erase suspend bit does not follow condition");
   AST_ERASE_ERR: assert property (ce_i && erase_fail_i |=> flag_o[5])
      else $error("erase failure not flagged");
   AST_ZERO_TO_ONE: assert property (ce_i && zero_to_one_i
      && program_supply_high_level_i && pattern_bits_i[5:0] == 6'h00 |=> flag_o[4])
      else $error("zero-to-one program not flagged");
   AST_PROG_ERR: assert property (ce_i && (prog_fail_i || prog_prot_i) |=> flag_o[4])
      else $error("program failure not flagged");
   // Set wins over clear, so the bit must be up on the very next edge
   AST_SUPPLY_ERR: assert property (ce_i && supply_bad_i |=> flag_o[3])
      else $error("supply error lost");
   AST_PROG_SUSP: assert property (ce_i |=> flag_o[2] == $past(prog_susp_i))
      else $error("program suspend bit does not follow condition");
   AST_PROT_RSVD: assert property (ce_i && erase_prot_i
      |=> flag_o[1] && flag_o[5] && !flag_o[0])
      else $error("protection error not flagged");
   AST_OTP_LOCKED: assert property (ce_i && otp_locked_hit_i |=> flag_o[1] && flag_o[4])
      else $error("locked area program not flagged");
   AST_FLAG_READ: assert property (rd_valid_o && $past(ce_i)
      |-> rd_data_o == $past(flag_o))
      else $error("flag read returned wrong byte");
   AST_READ_FLAG_ALL: assert property (ce_i && state_r == ST_IDLE && !cs_s2_r
      && opcode_valid_i && opcode_i == 8'h70 && proto_i != 2'h3 |=> cmd_accept_o)
      else $error("flag read refused in a protocol");
   AST_ERR_STICKY: assert property ($past(flag_o[5]) && !clear_done_o |-> flag_o[5])
      else $error("erase error dropped without clear");
   // Only a clear cycle with no erase event may drop the bit
   AST_CLEAR_ERASE: assert property (ce_i && clr_now && !erase_fail_i
      && !erase_prot_i |=> !flag_o[5])
      else $error("clear opcode left erase error set");
   AST_OP_WITH_ERR: assert property (ce_i && op_start_i && flag_o[5] |=> flag_o[1])
      else $error("operation with pending error not flagged");
   AST_CLEAR_NODATA: assert property (cmd_accept_o && cmd_code_o == 8'h50
      |-> max_bytes_o == 9'h000 && !stream_o)
      else $error("clear opcode expects data");
   AST_ID_EXT_ONLY: assert property (cmd_accept_o && $past(ce_i)
      && $past(proto_i) != 2'h0 |-> cmd_code_o != 8'h9E && cmd_code_o != 8'h9F)
      else $error("standard id read accepted outside extended");
   AST_ID_MULTI: assert property (cmd_accept_o && $past(ce_i)
      && $past(proto_i) == 2'h0 |-> cmd_code_o != 8'hAF)
      else $error("multi-line id read accepted in extended");
   AST_STREAM_HOLD: assert property (ce_i && stream_o && !cs_s2_r |=> stream_o)
      else $error("stream dropped while select low");
   AST_QUAD_NO_DUAL: assert property (cmd_accept_o && $past(ce_i)
      && $past(proto_i) == 2'h2 |-> cmd_code_o != 8'h3B && cmd_code_o != 8'hBB)
      else $error("dual read accepted in quad");
   AST_DUAL_NO_QUAD: assert property (cmd_accept_o && $past(ce_i)
      && $past(proto_i) == 2'h1 |-> cmd_code_o != 8'h6B && cmd_code_o != 8'hEB)
      else $error("quad read accepted in dual");
   AST_STATUS_WR_ONE: assert property (cmd_accept_o && cmd_code_o == 8'h01
      |-> max_bytes_o == 9'h001 && !stream_o)
      else $error("status write byte count wrong");
   AST_IGNORED_QUIET: assert property (state_r == ST_IGNORE
      |-> !cmd_accept_o && !rd_valid_o)
      else $error("ignored frame produced activity");

   COV_FLAG_READ: cover property (cmd_accept_o && cmd_code_o == 8'h70 ##[1:20] rd_valid_o);
   COV_CLEAR: cover property (flag_o[5] ##[1:20] clear_done_o);
   COV_IGNORE: cover property (cmd_ignored_o ##[1:20] state_r == ST_IDLE);
   COV_OVER: cover property (byte_over_o);
   COV_ZERO_TO_ONE: cover property (zero_to_one_i && program_supply_high_level_i ##1 flag_o[4]);
endmodule // flash_flag_status_cmd_decode
`default_nettype wire

/* bench/flash_host_model.sv */
// Host controller model that frames opcodes and data bytes
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
   // Clock
   input wire logic mclk_i,
   // Command frame
   output logic cs_n_o,
   output logic opcode_valid_o,
   output logic [7:0] opcode_o,
   output logic byte_done_o
);
   initial begin
      cs_n_o = 1'b1;
      opcode_valid_o = 1'b0;
      opcode_o = 8'h00;
      byte_done_o = 1'b0;
   end

   // Opcode goes out only once select has crossed the two-flop synchroniser
   task automatic start_cmd(input logic [7:0] op);
      @(posedge mclk_i);
      cs_n_o <= 1'b0;
      repeat (2) @(posedge mclk_i);
      opcode_valid_o <= 1'b1;
      opcode_o <= op;
      @(posedge mclk_i);
      opcode_valid_o <= 1'b0;
      // Released lines show the inverse so a stale byte never looks live
      opcode_o <= ~op;
   endtask

   // Gap idle cycles between bytes imitate a slow host
   task automatic send_bytes(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_i);
         byte_done_o <= 1'b1;
         @(posedge mclk_i);
         byte_done_o <= 1'b0;
         repeat (gap) @(posedge mclk_i);
      end
   endtask

   // Select stays high long enough for the block to see the frame end
   task automatic end_frame();
      @(posedge mclk_i);
      cs_n_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask
endmodule // flash_host_model
`default_nettype wire

/* bench/flash_flag_status_cmd_decode_test.sv */
// Self-checking bench for the flag register and opcode decoder
`timescale 1ns/100ps
`default_nettype none
module flash_flag_status_cmd_decode_test;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cs_n, opv, bdone;
   logic [7:0] opc;
   logic [1:0] proto = 2'h0;
   logic busy = 1'b0, esus = 1'b0, psus = 1'b0, start = 1'b0, ef = 1'b0, ep = 1'b0;
   logic pf = 1'b0, pp = 1'b0, otp = 1'b0, sbad = 1'b0, z1 = 1'b0, hv = 1'b0;
   logic [11:0] pat = 12'h000;
   logic [7:0] flag, code, rdat;
   logic [8:0] maxb;
   logic acc, ign, strm, over, clr, rdv;
   logic [7:0] exp_flag = 8'h88, exp_code = 8'h00, exp_rd = 8'h00, nf;
   logic [12:0] t = 13'h0000, t2;
   logic exp_acc = 1'b0, exp_ign = 1'b0, exp_clr = 1'b0, exp_rdv = 1'b0, rd70 = 1'b0;
   logic [7:0] ops [14] = '{8'h70, 8'h50, 8'h05, 8'h06, 8'h01, 8'h9E, 8'h9F, 8'hAF,
      8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB, 8'hFF};
   int failures = 0, num_checks = 0, n;
   // Model frame state: 0 idle, 1 accepted frame, 2 refused frame
   int st = 0;
   logic ce = 1'b1, s1 = 1'b1, s2 = 1'b1;

   always #5 mclk_i = ~mclk_i;

   flash_flag_status_cmd_decode flash_flag_status_cmd_decode_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .cs_n_i(cs_n),
      .opcode_valid_i(opv), .opcode_i(opc), .proto_i(proto), .byte_done_i(bdone),
      .pe_busy_i(busy), .erase_susp_i(esus), .prog_susp_i(psus), .op_start_i(start),
      .erase_fail_i(ef), .erase_prot_i(ep), .prog_fail_i(pf), .prog_prot_i(pp),
      .otp_locked_hit_i(otp), .supply_bad_i(sbad), .zero_to_one_i(z1),
      .program_supply_high_level_i(hv), .pattern_bits_i(pat),
      .flag_o(flag), .cmd_accept_o(acc), .cmd_ignored_o(ign), .cmd_code_o(code),
      .max_bytes_o(maxb), .stream_o(strm), .byte_over_o(over), .clear_done_o(clr),
      .rd_valid_o(rdv), .rd_data_o(rdat));

   flash_host_model flash_host_model_inst (
      .mclk_i(mclk_i), .cs_n_o(cs_n), .opcode_valid_o(opv), .opcode_o(opc),
      .byte_done_o(bdone));

   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      num_checks++;
      if (seen !== expv) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask

   task automatic end_sim();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Support mask per protocol, byte limit, continuous flag
   function automatic logic [12:0] lookup(input logic [7:0] op);
      case (op)
         8'h70, 8'h05, 8'h0B: lookup = {3'h7, 9'h1FF, 1'b1};
         8'h50, 8'h06: lookup = {3'h7, 9'h000, 1'b0};
         8'h01: lookup = {3'h7, 9'h001, 1'b0};
         8'h9E, 8'h9F: lookup = {3'h1, 9'h014, 1'b0};
         8'hAF: lookup = {3'h6, 9'h003, 1'b0};
         8'h3B, 8'hBB: lookup = {3'h3, 9'h1FF, 1'b1};
         8'h6B, 8'hEB: lookup = {3'h5, 9'h1FF, 1'b1};
         default: lookup = 13'h0000;
      endcase
   endfunction

   function automatic logic rb();
      return $urandom_range(15) == 0;
   endfunction

   // Reference model, advanced on the same edges as the block
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         exp_flag = 8'h88;
         {exp_acc, exp_ign, exp_clr, exp_rdv, rd70, s1, s2} = 7'h03;
         st = 0;
      end else if (ce) begin
         t = lookup(opc);
         // Opcode is taken only when idle and select has crossed both flops
         exp_acc = st == 0 && !s2 && opv && proto != 2'h3 && t[10 + proto];
         exp_ign = st == 0 && !s2 && opv && !exp_acc;
         exp_clr = exp_acc && opc == 8'h50;
         exp_rdv = st == 1 && !s2 && bdone && rd70;
         if (exp_rdv) exp_rd = exp_flag;
         if (exp_acc) exp_code = opc;
         if (exp_acc) rd70 = opc == 8'h70;
         if (st != 0 && s2) st = 0;
         else if (exp_acc) st = 1;
         else if (exp_ign) st = 2;
         s2 = s1;
         s1 = cs_n;
         nf = exp_flag;
         // Clear first so an event in the same cycle wins
         if (exp_clr) nf = nf & 8'hC5;
         if (ef || ep) nf[5] = 1'b1;
         if (pf || pp || otp || (z1 && hv && pat[5:0] == 6'h00)) nf[4] = 1'b1;
         if (sbad) nf[3] = 1'b1;
         if (ep || pp || otp || (start && (exp_flag & 8'h3A) != 8'h00)) nf[1] = 1'b1;
         nf[7] = !busy;
         nf[6] = esus;
         nf[2] = psus;
         nf[0] = 1'b0;
         exp_flag = nf;
      end
   end

   always @(negedge mclk_i) begin
      check(16'(flag & 8'hC5), 16'(exp_flag & 8'hC5));
      check(16'(flag & 8'h3A), 16'(exp_flag & 8'h3A));
      check(16'(acc), 16'(exp_acc));
      check(16'(ign), 16'(exp_ign));
      check(16'(clr), 16'(exp_clr));
      check(16'(rdv), 16'(exp_rdv));
      if (exp_rdv) check(16'(rdat), 16'(exp_rd));
      if (exp_acc) check(16'(code), 16'(exp_code));
      if (exp_acc) check(16'(maxb), 16'(t[9:1]));
      if (exp_acc) check(16'(strm), 16'(t[0]));
   end

   initial begin
      void'($urandom(3));
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // each of the 14 opcodes in ops in every protocol, write enable before status write
      for (int p = 0; p < 4; p++) begin
         foreach (ops[i]) begin
            @(posedge mclk_i);
            proto <= 2'(p);
            t2 = lookup(ops[i]);
            flash_host_model_inst.start_cmd(ops[i]);
            if (p != 3 && t2[10 + p]) begin
               n = t2[0] ? 2 : int'(t2[9:1]) + 1;
               flash_host_model_inst.send_bytes(n, $urandom_range(2));
               #1;
               check(16'(over), 16'(!t2[0]));
            end
            flash_host_model_inst.end_frame();
            #1;
            check(16'(strm), 16'h0000);
         end
      end
      // random engine events against reads and clears
      fork
         repeat (600) begin
            @(posedge mclk_i);
            busy <= $urandom_range(3) == 0;
            ce <= $urandom_range(7) != 0;
            esus <= $urandom_range(7) == 0;
            psus <= $urandom_range(7) == 0;
            start <= rb();
            ef <= rb();
            ep <= rb();
            pf <= rb();
            pp <= rb();
            otp <= rb();
            sbad <= rb();
            z1 <= rb();
            hv <= 1'($urandom_range(1));
            pat <= $urandom_range(1) ? 12'h0C0 : 12'($urandom);
         end
         repeat (20) begin
            @(posedge mclk_i);
            proto <= 2'($urandom_range(2));
            flash_host_model_inst.start_cmd($urandom_range(1) ? 8'h70 : 8'h50);
            flash_host_model_inst.send_bytes(2, 1);
            flash_host_model_inst.end_frame();
         end
      join
      end_sim();
   end

   initial begin
      #200000;
      failures++;
      end_sim();
   end
endmodule // flash_flag_status_cmd_decode_test
`default_nettype wire
